// ==== design/ocp_channel.sv ====
/*
 * ocp_channel: one output compare channel with an AXI4-Lite register
 * slave, sticky event status with mask and a level interrupt.
 * Assumes the timebases run on mclk_i and step only on tcy_tick_o.
 */
`timescale 1ns/1ps

module ocp_channel
	import ocp_pkg::*;
(
	// clock and reset
	input  wire logic          mclk_i,
	input  wire logic          reset_i,
	// timebases
	input  wire ocp_timebase_t tb0_i,
	input  wire ocp_timebase_t tb1_i,
	output logic               tcy_tick_o,
	// compare output and interrupt
	output logic               compare_output_pin_o,
	output logic               irq_o,
	// axi4-lite write address
	input  wire logic [7:0]    s_axi_awaddr_i,
	input  wire logic          s_axi_awvalid_i,
	output logic               s_axi_awready_o,
	// axi4-lite write data
	input  wire logic [31:0]   s_axi_wdata_i,
	input  wire logic [3:0]    s_axi_wstrb_i,
	input  wire logic          s_axi_wvalid_i,
	output logic               s_axi_wready_o,
	// axi4-lite write response
	output logic [1:0]         s_axi_bresp_o,
	output logic               s_axi_bvalid_o,
	input  wire logic          s_axi_bready_i,
	// axi4-lite read address
	input  wire logic [7:0]    s_axi_araddr_i,
	input  wire logic          s_axi_arvalid_i,
	output logic               s_axi_arready_o,
	// axi4-lite read data
	output logic [31:0]        s_axi_rdata_o,
	output logic [1:0]         s_axi_rresp_o,
	output logic               s_axi_rvalid_o,
	input  wire logic          s_axi_rready_i
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic [7:0]    div_r;
	logic [7:0]    aw_addr_r;
	logic          aw_held_r;
	logic [31:0]   w_data_r;
	logic [3:0]    w_strb_r;
	logic          w_held_r;
	logic          wr_go;
	logic          wr_ok;
	logic          ctl_wr;
	ocp_mode_t     mode_r;
	ocp_mode_t     mode_nxt;
	logic          tsel_r;
	logic [15:0]   pri_r;
	logic [15:0]   sec_r;
	logic          stat_r;
	logic          mask_r;
	ocp_seq_t      seq_r;
	ocp_timebase_t tb;
	logic          pri_eq;
	logic          sec_eq;
	logic          pri_eq_r;
	logic          sec_eq_r;
	logic          fire_r;
	logic          ev0_r;
	logic          ev1_r;
	logic          evt_set;
	logic [31:0]   rd_word;
	logic          rd_ok;

	// byte-lane merge for a 16-bit register
	function automatic logic [15:0] merge16(
		input logic [15:0] old,
		input logic [31:0] data,
		input logic [3:0]  strb
	);
		logic [15:0] res;
		res = old;
		if (strb[0])
		begin
			res[7:0] = data[7:0];
		end
		if (strb[1])
		begin
			res[15:8] = data[15:8];
		end
		return res;
	endfunction : merge16

	// ------------------------------------------------------------
	// instruction clock enable
	// ------------------------------------------------------------

	// divider pulsing once per instruction clock
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			div_r      <= 8'h00;
			tcy_tick_o <= 1'b0;
		end
		else if (div_r >= OCP_TCY_DIV - 8'h01)
		begin
			div_r      <= 8'h00;
			tcy_tick_o <= 1'b1;
		end
		else
		begin
			div_r      <= div_r + 8'h01;
			tcy_tick_o <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// axi4-lite write path
	// ------------------------------------------------------------

	// address and data are taken in either order
	assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid_o;

	// decode of the held write address
	always_comb
	begin
		unique case (aw_addr_r)
			OCP_ADDR_CTRL, OCP_ADDR_PRI, OCP_ADDR_SEC,
			OCP_ADDR_STAT, OCP_ADDR_MASK, OCP_ADDR_PIN: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	assign ctl_wr   = wr_go && (aw_addr_r == OCP_ADDR_CTRL) && w_strb_r[0];
	assign mode_nxt = ocp_mode_t'(w_data_r[2:0]);

	// write address channel
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			aw_held_r       <= 1'b0;
			aw_addr_r       <= 8'h00;
			s_axi_awready_o <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid_i && s_axi_awready_o)
			begin
				aw_held_r <= 1'b1;
				aw_addr_r <= {s_axi_awaddr_i[7:2], 2'h0};
			end
			else if (wr_go)
			begin
				aw_held_r <= 1'b0;
			end
			s_axi_awready_o <= !aw_held_r && !s_axi_awready_o
				&& !s_axi_awvalid_i ? 1'b1
				: !aw_held_r && !(s_axi_awvalid_i && s_axi_awready_o);
		end
	end

	// write data channel
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			w_held_r       <= 1'b0;
			w_data_r       <= 32'h0000_0000;
			w_strb_r       <= 4'h0;
			s_axi_wready_o <= 1'b0;
		end
		else
		begin
			if (s_axi_wvalid_i && s_axi_wready_o)
			begin
				w_held_r <= 1'b1;
				w_data_r <= s_axi_wdata_i;
				w_strb_r <= s_axi_wstrb_i;
			end
			else if (wr_go)
			begin
				w_held_r <= 1'b0;
			end
			s_axi_wready_o <= !w_held_r && !(s_axi_wvalid_i && s_axi_wready_o);
		end
	end

	// write response, one per write
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= OCP_RESP_OKAY;
		end
		else if (wr_go)
		begin
			s_axi_bvalid_o <= 1'b1;
			s_axi_bresp_o  <= wr_ok ? OCP_RESP_OKAY : OCP_RESP_SLV;
		end
		else if (s_axi_bready_i)
		begin
			s_axi_bvalid_o <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------

	// mode and timebase select
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			mode_r <= OCP_MODE_OFF;
			tsel_r <= 1'b0;
		end
		else if (ctl_wr)
		begin
			mode_r <= mode_nxt;
			tsel_r <= w_data_r[OCP_TSEL_BIT];
		end
	end

	// compare values
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			pri_r <= OCP_RST_16;
			sec_r <= OCP_RST_16;
		end
		else if (wr_go && aw_addr_r == OCP_ADDR_PRI)
		begin
			pri_r <= merge16(pri_r, w_data_r, w_strb_r);
		end
		else if (wr_go && aw_addr_r == OCP_ADDR_SEC)
		begin
			sec_r <= merge16(sec_r, w_data_r, w_strb_r);
		end
	end

	// ------------------------------------------------------------
	// compare and sequencing
	// ------------------------------------------------------------

	// selected timebase, which wraps at its period itself
	assign tb = tsel_r ? tb1_i : tb0_i;

	// equality only while running and with a nonzero period
	assign pri_eq = tb.run && (tb.period != 16'h0000)
		&& (tb.count == pri_r);
	assign sec_eq = tb.run && (tb.period != 16'h0000)
		&& (tb.count == sec_r);

	// match stage: one fire per new equality, sampled each tick
	always_ff @(posedge mclk_i)
	begin
		if (reset_i || ctl_wr)
		begin
			pri_eq_r <= 1'b0;
			sec_eq_r <= 1'b0;
			fire_r   <= 1'b0;
		end
		else if (tcy_tick_o)
		begin
			pri_eq_r <= pri_eq;
			sec_eq_r <= sec_eq;
			unique case (seq_r)
				OCP_SEQ_ARMED: fire_r <= pri_eq && !pri_eq_r;
				OCP_SEQ_FALL:  fire_r <= sec_eq && !sec_eq_r;
				default:       fire_r <= 1'b0;
			endcase
		end
	end

	// sequencer for single shot, toggle and pulse modes
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			seq_r <= OCP_SEQ_IDLE;
		end
		else if (ctl_wr)
		begin
			unique case (mode_nxt)
				OCP_MODE_HIGH, OCP_MODE_LOW,
				OCP_MODE_TOG, OCP_MODE_PULSE: seq_r <= OCP_SEQ_ARMED;
				default:                      seq_r <= OCP_SEQ_IDLE;
			endcase
		end
		else if (tcy_tick_o && fire_r)
		begin
			unique case (seq_r)
				OCP_SEQ_ARMED:
					seq_r <= (mode_r == OCP_MODE_PULSE) ? OCP_SEQ_FALL
						: (mode_r == OCP_MODE_TOG) ? OCP_SEQ_ARMED
						: OCP_SEQ_DONE;
				OCP_SEQ_FALL: seq_r <= OCP_SEQ_DONE;
				default:      seq_r <= seq_r;
			endcase
		end
	end

	// compare output pin
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			compare_output_pin_o <= 1'b0;
		end
		else if (ctl_wr)
		begin
			unique case (mode_nxt)
				OCP_MODE_HIGH:  compare_output_pin_o <= 1'b0;
				OCP_MODE_LOW:   compare_output_pin_o <= 1'b1;
				OCP_MODE_PULSE: compare_output_pin_o <= 1'b0;
				OCP_MODE_TOG:
					if (mode_r != OCP_MODE_HIGH && mode_r != OCP_MODE_LOW)
					begin
						compare_output_pin_o <= 1'b0;
					end
					else
					begin
						compare_output_pin_o <= compare_output_pin_o;
					end
				default:        compare_output_pin_o <= 1'b0;
			endcase
		end
		else if (tcy_tick_o && fire_r)
		begin
			// applied one tick after the match
			unique case (mode_r)
				OCP_MODE_HIGH:  compare_output_pin_o <= 1'b1;
				OCP_MODE_LOW:   compare_output_pin_o <= 1'b0;
				OCP_MODE_TOG:   compare_output_pin_o <= !compare_output_pin_o;
				OCP_MODE_PULSE: compare_output_pin_o <= (seq_r == OCP_SEQ_ARMED);
				default:        compare_output_pin_o <= compare_output_pin_o;
			endcase
		end
	end

	// ------------------------------------------------------------
	// event flag and interrupt
	// ------------------------------------------------------------

	// two-tick delay from pin change to flag
	always_ff @(posedge mclk_i)
	begin
		if (reset_i || ctl_wr)
		begin
			ev0_r <= 1'b0;
			ev1_r <= 1'b0;
		end
		else if (tcy_tick_o)
		begin
			ev0_r <= fire_r && !(mode_r == OCP_MODE_PULSE
				&& seq_r == OCP_SEQ_ARMED);
			ev1_r <= ev0_r;
		end
	end

	assign evt_set = tcy_tick_o && ev1_r;

	// sticky status, set wins over write-one clear
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			stat_r <= 1'b0;
		end
		else if (evt_set)
		begin
			stat_r <= 1'b1;
		end
		else if (wr_go && aw_addr_r == OCP_ADDR_STAT && w_strb_r[0]
			&& w_data_r[OCP_EVT_BIT])
		begin
			stat_r <= 1'b0;
		end
	end

	// mask register
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			mask_r <= 1'b0;
		end
		else if (wr_go && aw_addr_r == OCP_ADDR_MASK && w_strb_r[0])
		begin
			mask_r <= w_data_r[OCP_EVT_BIT];
		end
	end

	// level interrupt
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			irq_o <= 1'b0;
		end
		else
		begin
			irq_o <= stat_r && mask_r;
		end
	end

	// ------------------------------------------------------------
	// axi4-lite read path
	// ------------------------------------------------------------

	// read mux
	always_comb
	begin
		rd_word = 32'h0000_0000;
		rd_ok   = 1'b1;
		unique case ({s_axi_araddr_i[7:2], 2'h0})
			OCP_ADDR_CTRL: rd_word = {28'h0, tsel_r, mode_r};
			OCP_ADDR_PRI:  rd_word = {16'h0, pri_r};
			OCP_ADDR_SEC:  rd_word = {16'h0, sec_r};
			OCP_ADDR_STAT: rd_word = {31'h0, stat_r};
			OCP_ADDR_MASK: rd_word = {31'h0, mask_r};
			OCP_ADDR_PIN:  rd_word = {27'h0, seq_r, compare_output_pin_o};
			default:       rd_ok   = 1'b0;
		endcase
	end

	// read address and data, one read at a time
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= 32'h0000_0000;
			s_axi_rresp_o   <= OCP_RESP_OKAY;
		end
		else if (s_axi_arvalid_i && s_axi_arready_o)
		begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b1;
			s_axi_rdata_o   <= rd_word;
			s_axi_rresp_o   <= rd_ok ? OCP_RESP_OKAY : OCP_RESP_SLV;
		end
		else if (s_axi_rvalid_o)
		begin
			if (s_axi_rready_i)
			begin
				s_axi_rvalid_o <= 1'b0;
			end
		end
		else
		begin
			s_axi_arready_o <= 1'b1;
		end
	end

endmodule : ocp_channel

// ==== design/ocp_pkg.sv ====
/*
 * ocp_pkg: constants, types and register map of the output compare
 * channel. Assumes one 125 MHz clock shared by the channel, its two
 * timebases and the AXI4-Lite master.
 */
package ocp_pkg;

	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] OCP_ADDR_CTRL = 8'h00;
	localparam logic [7:0] OCP_ADDR_PRI  = 8'h04;
	localparam logic [7:0] OCP_ADDR_SEC  = 8'h08;
	localparam logic [7:0] OCP_ADDR_STAT = 8'h0c;
	localparam logic [7:0] OCP_ADDR_MASK = 8'h10;
	localparam logic [7:0] OCP_ADDR_PIN  = 8'h14;

	// ------------------------------------------------------------
	// fields and reset values
	// ------------------------------------------------------------
	localparam int         OCP_TSEL_BIT  = 3;
	localparam int         OCP_EVT_BIT   = 0;
	localparam logic [15:0] OCP_RST_16   = 16'h0000;
	localparam logic [1:0] OCP_RESP_OKAY = 2'h0;
	localparam logic [1:0] OCP_RESP_SLV  = 2'h2;

	// ------------------------------------------------------------
	// timing: instruction clock as a divided enable
	// ------------------------------------------------------------
	localparam int         OCP_CLK_MHZ   = 125;
	localparam int         OCP_TCY_MHZ   = 125;
	localparam logic [7:0] OCP_TCY_DIV   = 8'(OCP_CLK_MHZ / OCP_TCY_MHZ);

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		OCP_MODE_OFF   = 3'h0,
		OCP_MODE_HIGH  = 3'h1,
		OCP_MODE_LOW   = 3'h2,
		OCP_MODE_TOG   = 3'h3,
		OCP_MODE_PULSE = 3'h4,
		OCP_MODE_CONT  = 3'h5,
		OCP_MODE_PWM   = 3'h6,
		OCP_MODE_PWMF  = 3'h7
	} ocp_mode_t;

	typedef enum logic [3:0] {
		OCP_SEQ_IDLE  = 4'b0001,
		OCP_SEQ_ARMED = 4'b0010,
		OCP_SEQ_FALL  = 4'b0100,
		OCP_SEQ_DONE  = 4'b1000
	} ocp_seq_t;

	typedef struct packed {
		logic [15:0] count;
		logic [15:0] period;
		logic        run;
	} ocp_timebase_t;

endpackage : ocp_pkg

// ==== verification/ocp_channel_chk.sv ====
/* ocp_channel_chk: assertions on the compare channel's ports.
   Assumes registers change only through completed axi writes. */
`timescale 1ns/1ps

module ocp_channel_chk
	import ocp_pkg::*;
(
	// clock, timebases, outputs
	input wire logic          mclk_i,
	input wire logic          reset_i,
	input wire ocp_timebase_t tb0_i,
	input wire ocp_timebase_t tb1_i,
	input wire logic          tcy_tick_o,
	input wire logic          compare_output_pin_o,
	input wire logic          irq_o,
	// axi write side
	input wire logic [7:0]    s_axi_awaddr_i,
	input wire logic          s_axi_awvalid_i,
	input wire logic          s_axi_awready_o,
	input wire logic [31:0]   s_axi_wdata_i,
	input wire logic          s_axi_wvalid_i,
	input wire logic          s_axi_wready_o,
	input wire logic          s_axi_bvalid_o,
	input wire logic          s_axi_bready_i
);
	logic [7:0]    wa_r;
	logic [15:0]   wd_r;
	logic [3:0]    ctl_r;
	logic [15:0]   pri_r;
	logic [15:0]   sec_r;
	logic          msk_r;
	logic [2:0]    q_r;
	logic          done_r;
	logic [2:0]    md;
	logic          p;
	logic          q;
	logic          pm;
	logic          sm;
	ocp_timebase_t tb;
	logic [7:0]    gap_r;

	default clocking @(posedge mclk_i); endclocking
	default disable iff (reset_i);

	// matches of the selected timebase
	assign tb = ctl_r[3] ? tb1_i : tb0_i;
	assign md = ctl_r[2:0];
	assign p  = compare_output_pin_o;
	assign q  = q_r[2];
	assign pm = tcy_tick_o && tb.run && tb.period != 16'h0000 && tb.count == pri_r;
	assign sm = tcy_tick_o && tb.run && tb.period != 16'h0000 && tb.count == sec_r;

	// shadow of the registers behind the pin
	always_ff @(posedge mclk_i)
	begin
		if (s_axi_awvalid_i && s_axi_awready_o) wa_r <= s_axi_awaddr_i;
		if (s_axi_wvalid_i && s_axi_wready_o) wd_r <= s_axi_wdata_i[15:0];
		if (reset_i)
		begin
			ctl_r <= 4'h0;
			pri_r <= 16'h0000;
			sec_r <= 16'h0000;
			msk_r <= 1'b0;
		end
		else if (s_axi_bvalid_o && s_axi_bready_i)
		begin
			if (wa_r == OCP_ADDR_CTRL) ctl_r <= wd_r[3:0];
			if (wa_r == OCP_ADDR_PRI) pri_r <= wd_r;
			if (wa_r == OCP_ADDR_SEC) sec_r <= wd_r;
			if (wa_r == OCP_ADDR_MASK) msk_r <= wd_r[0];
		end
	end

	// write bus quiet for four cycles; pulse already finished
	always_ff @(posedge mclk_i)
	begin
		q_r    <= (reset_i || s_axi_awvalid_i || s_axi_wvalid_i || s_axi_bvalid_o) ? 3'h0
			: q_r + 3'(!q_r[2]);
		done_r <= q && !reset_i && (done_r || (md == 3'h4 && $fell(p)));
	end

	// cycles since the last tick; all ones after reset so the first tick lines up
	always_ff @(posedge mclk_i)
	begin
		gap_r <= reset_i ? 8'hff : tcy_tick_o ? 8'h00 : gap_r + 8'h01;
	end

	sequence flag_lag;
		!irq_o [*2] ##1 irq_o;
	endsequence

	reset_clear_a: assert property ($fell(reset_i) |-> !p && !irq_o)
		else $error("pin or irq high after reset");
	tog_step_a: assert property (q && md == 3'h3 && $past(pm, 2) |-> $changed(p))
		else $error("no toggle after match");
	hold_still_a: assert property (q && !$past(pm, 2) && !$past(sm, 2) |-> $stable(p))
		else $error("pin moved without match");
	force_level_a: assert property (q && md inside {3'h1, 3'h2} && $past(pm, 2) |-> p == md[0])
		else $error("forced level wrong");
	off_low_a: assert property (q && md == 3'h0 |-> !p)
		else $error("pin high while disabled");
	rise_cause_a: assert property (q && $rose(p) |-> $past(pm, 2))
		else $error("rise without primary match");
	fall_cause_a: assert property (q && md == 3'h4 && $fell(p) |-> $past(sm, 2))
		else $error("fall without secondary match");
	pulse_once_a: assert property (done_r && q |-> !p)
		else $error("second pulse");
	tog_flag_a: assert property (q && md == 3'h3 && msk_r && !irq_o && $changed(p) |=> flag_lag)
		else $error("toggle flag timing");
	pulse_flag_a: assert property (q && md == 3'h4 && msk_r && !irq_o && $fell(p) |=> flag_lag)
		else $error("pulse flag timing");
	irq_mask_a: assert property (q && !msk_r |-> !irq_o)
		else $error("masked irq high");
	tick_gap_a: assert property (tcy_tick_o == (gap_r == OCP_TCY_DIV - 8'h01))
		else $error("tick spacing wrong");
endmodule : ocp_channel_chk

// ==== verification/ocp_far_model.sv ====
/* ocp_far_model: timebases feeding the channel and a watcher on its pin.
   Assumes one clock; the bench pulses start_i to launch a counted run. */
`timescale 1ns/1ps

module ocp_far_model
	import ocp_pkg::*;
(
	// clock, reset, channel side
	input  wire logic        mclk_i,
	input  wire logic        reset_i,
	input  wire logic        tick_i,
	input  wire logic        pin_i,
	// bench control
	input  wire logic        tsel_i,
	input  wire logic        start_i,
	input  wire logic [7:0]  nticks_i,
	input  wire logic [15:0] period_i,
	// timebases and edge counts
	output ocp_timebase_t    tb0_o,
	output ocp_timebase_t    tb1_o,
	output int               rises_o,
	output int               falls_o
);
	logic [15:0]   cnt_r;
	logic [3:0]    free_r;
	logic [7:0]    left_r;
	logic          pin_r;
	ocp_timebase_t main_w;
	ocp_timebase_t free_w;

	// selected timer runs the test, the other one is a busy decoy
	assign main_w = '{cnt_r, period_i, left_r != 8'h00};
	assign free_w = '{{12'h000, free_r}, 16'h000f, 1'b1};
	assign tb0_o  = tsel_i ? free_w : main_w;
	assign tb1_o  = tsel_i ? main_w : free_w;

	// count up to the period, back to zero on the next tick
	always_ff @(posedge mclk_i)
	begin
		free_r <= reset_i ? 4'h0 : free_r + 4'(tick_i);
		if (reset_i || start_i)
		begin
			cnt_r  <= 16'h0000;
			left_r <= reset_i ? 8'h00 : nticks_i;
		end
		else if (tick_i && left_r != 8'h00)
		begin
			left_r <= left_r - 8'h01;
			cnt_r  <= (cnt_r >= period_i) ? 16'h0000 : cnt_r + 16'h0001;
		end
	end

	// count pin edges since the last start
	always_ff @(posedge mclk_i)
	begin
		pin_r   <= pin_i;
		rises_o <= (reset_i || start_i) ? 0 : rises_o + int'(pin_i && !pin_r);
		falls_o <= (reset_i || start_i) ? 0 : falls_o + int'(!pin_i && pin_r);
	end
endmodule : ocp_far_model

// ==== verification/test_output_compare_toggle_pulse.sv ====
/* test_output_compare_toggle_pulse: self-checking bench of the channel.
   Assumes ocp_channel, ocp_far_model and ocp_channel_chk are compiled. */
`timescale 1ns/1ps

module test_output_compare_toggle_pulse
	import ocp_pkg::*;
;
	logic          mclk_i  = 1'b0;
	logic          reset_i = 1'b1;
	logic [7:0]    awa     = 8'h00;
	logic          awv     = 1'b0;
	logic [31:0]   wd      = 32'h0;
	logic          wv      = 1'b0;
	logic [7:0]    ara     = 8'h00;
	logic          arv     = 1'b0;
	logic          tsel    = 1'b0;
	logic          start   = 1'b0;
	logic [7:0]    nt      = 8'h00;
	logic [15:0]   per     = 16'h0000;
	logic          tick, pin, irq, awrdy, wrdy, bv, arrdy, rv, ts;
	logic [1:0]    bresp, rresp, e;
	logic [2:0]    md;
	logic [31:0]   rdat, d;
	ocp_timebase_t tb0, tb1;
	int            n_fail = 0;
	int            compares = 0;
	int            rises, falls, it, p, c, s, m, pre, hit, fa, ep, er, ef, fl;

	// 125 MHz clock
	always #4 mclk_i = ~mclk_i;

	ocp_channel u_ocp_channel (.mclk_i(mclk_i), .reset_i(reset_i), .tb0_i(tb0), .tb1_i(tb1),
		.tcy_tick_o(tick), .compare_output_pin_o(pin), .irq_o(irq), .s_axi_awaddr_i(awa),
		.s_axi_awvalid_i(awv), .s_axi_awready_o(awrdy), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf),
		.s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv),
		.s_axi_bready_i(1'b1), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
		.s_axi_arready_o(arrdy), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rv), .s_axi_rready_i(1'b1));

	ocp_far_model u_ocp_far_model (.mclk_i(mclk_i), .reset_i(reset_i), .tick_i(tick),
		.pin_i(pin), .tsel_i(tsel), .start_i(start), .nticks_i(nt), .period_i(per),
		.tb0_o(tb0), .tb1_o(tb1), .rises_o(rises), .falls_o(falls));

	task automatic test_done();
		if (n_fail == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : test_done

	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] y);
		compares++;
		if (y !== x)
		begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", n, x, y);
		end
	endtask : chk

	// bounded wait ran out: count it and stop
	task automatic lim(input int t);
		if (t >= 60)
		begin
			chk("wait", 0, 1);
			test_done();
		end
	endtask : lim

	task automatic wr(input logic [7:0] a, input logic [31:0] x, input logic [1:0] r);
		int t;
		awa <= a;
		wd  <= x;
		awv <= 1'b1;
		wv  <= 1'b1;
		t = 0;
		do
		begin
			@(posedge mclk_i);
			if (awrdy) awv <= 1'b0;
			if (wrdy) wv <= 1'b0;
			t++;
		end
		while (!bv && t < 60);
		lim(t);
		chk("bresp", r, bresp);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		int t;
		ara <= a;
		arv <= 1'b1;
		t = 0;
		do
		begin
			@(posedge mclk_i);
			if (arrdy) arv <= 1'b0;
			t++;
		end
		while (!rv && t < 60);
		lim(t);
		d = rdat;
		e = rresp;
	endtask : rd

	// launch the selected timer for n ticks, then let the pipeline settle
	task automatic run(input int n, input int w);
		nt    <= 8'(n);
		start <= 1'b1;
		@(posedge mclk_i);
		start <= 1'b0;
		repeat (w) @(posedge mclk_i);
	endtask : run

	initial
	begin
		void'($urandom(58));
		repeat (5) @(posedge mclk_i);
		reset_i <= 1'b0;
		@(posedge mclk_i);
		for (it = 0; it < 5; it++)
		begin
			rd(8'(4 * it));
			chk("reset value", 0, d);
		end
		wr(8'h18, 32'h1, OCP_RESP_SLV);
		rd(8'h18);
		chk("rresp", OCP_RESP_SLV, e);
		for (it = 0; it < 24; it++)
		begin
			md  = 3'(1 + it % 4);
			ts  = 1'($urandom % 2);
			p   = (it == 9) ? 0 : $urandom % 12 + 1;
			c   = $urandom % 15 + 1;
			c   = (it == 9) ? 0 : (it == 6) ? p : c;
			s   = c + 2 + $urandom % 6;
			m   = $urandom % 2;
			pre = (md == 3'h3) ? $urandom % 3 : 0;
			wr(OCP_ADDR_CTRL, 32'((it % 4 == 0) ? 0 : 4 + it % 4), OCP_RESP_OKAY);
			chk("disabled pin", 0, pin);
			tsel <= ts;
			per  <= 16'(p);
			wr(OCP_ADDR_PRI, 32'(c), OCP_RESP_OKAY);
			wr(OCP_ADDR_SEC, 32'(s), OCP_RESP_OKAY);
			wr(OCP_ADDR_MASK, 32'(m), OCP_RESP_OKAY);
			wr(OCP_ADDR_STAT, 32'h1, OCP_RESP_OKAY);
			if (pre != 0) wr(OCP_ADDR_CTRL, 32'({ts, 3'(pre)}), OCP_RESP_OKAY);
			wr(OCP_ADDR_CTRL, 32'({ts, md}), OCP_RESP_OKAY);
			rd(OCP_ADDR_CTRL);
			chk("control", 32'({ts, md}), d);
			run(3 * p + 3, 3 * p + 12);
			hit = (p != 0 && c <= p);
			fa  = hit && s <= p;
			ep  = (md == 1) ? hit : (md == 2) ? !hit : (md == 3) ? hit ^ (pre == 2) : hit && !fa;
			er  = (md == 2) ? 0 : (md == 3) ? (hit ? 2 - (pre == 2) : 0) : hit;
			ef  = (md == 1) ? 0 : (md == 2) ? hit : (md == 3) ? (hit ? 1 + (pre == 2) : 0) : fa;
			fl  = (md == 4) ? fa : hit;
			chk("pin", ep, pin);
			chk("rises", er, rises);
			chk("falls", ef, falls);
			rd(OCP_ADDR_STAT);
			chk("status", fl, d);
			chk("irq", fl & m, irq);
			rd(OCP_ADDR_PIN);
			chk("pin readback", ep, d[0]);
			wr(OCP_ADDR_PRI, 32'h0, OCP_RESP_OKAY);
			per <= 16'h0000;
			run(8, 12);
			chk("pin kept", ep, pin);
		end
		test_done();
	end
endmodule : test_output_compare_toggle_pulse

bind ocp_channel ocp_channel_chk u_ocp_channel_chk (.mclk_i, .reset_i, .tb0_i, .tb1_i,
	.tcy_tick_o, .compare_output_pin_o, .irq_o, .s_axi_awaddr_i, .s_axi_awvalid_i,
	.s_axi_awready_o, .s_axi_wdata_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o,
	.s_axi_bready_i);
